// file: oclf_osc_ctrl.sv
// Oscillator control with unlock protection, clock source selection and failover.
// Assumes an APB master on clk_sys and raw oscillator activity pins, one per source.
`timescale 1ns/1ns
module oclf_osc_ctrl import oclf_pkg::*; #(
  parameter int unsigned FAIL_TIMEOUT_CYC = FAIL_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire oclf_apb_req_t apb_req,
  output oclf_apb_rsp_t apb_rsp,
  input wire logic [NUM_SRC-1:0] osc_act_pin,
  output logic [1:0] sys_clk_sel,
  output logic internal_precision_osc_en,
  output logic wdt_osc_en,
  output logic irq,
  output logic clk_fail_nmi
);

  oclf_state_t st_ff;
  oclf_state_t nxt_st;

  logic pri_fail;
  logic wdt_fail;
  logic pri_pin;
  logic setup;
  logic done;
  logic wr;
  logic [7:0] wbyte;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] evt;
  logic commit;

  // Mapped register check, used only for the error answer
  function automatic logic reg_hit(input logic [11:0] addr);
    reg_hit = (addr == OFF_OSC_CTRL) || (addr == OFF_IRQ_STATUS) ||
              (addr == OFF_IRQ_CLEAR) || (addr == OFF_IRQ_ENABLE) ||
              (addr == OFF_CLK_STATE);
  endfunction

  // Read data for an address; narrow registers sit in the low bits
  function automatic logic [31:0] rd_val(input logic [11:0] addr, input oclf_state_t s);
    logic [31:0] v;
    v = 32'h0;
    case (addr)
      OFF_OSC_CTRL: begin
        v[7:0] = s.ctrl;
      end
      OFF_IRQ_STATUS: begin
        v[IRQ_W-1:0] = s.status;
      end
      OFF_IRQ_ENABLE: begin
        v[IRQ_W-1:0] = s.irq_en;
      end
      OFF_CLK_STATE: begin
        v[CS_SRC_LSB +: 2] = s.active_src;
        v[CS_HALF_BIT] = (s.ul == UL_HALF);
        v[CS_OPEN_BIT] = (s.ul == UL_OPEN);
        v[CS_FALLBACK_BIT] = s.fallback;
      end
      default: begin
        v = 32'h0;
      end
    endcase
    rd_val = v;
  endfunction

  // Primary detector watches the configured source, so a switch with the
  // detector left on can see a stalled input and report a failure
  assign pri_pin = osc_act_pin[st_ff.ctrl.clock_source_select];

  oclf_fail_det #(
    .TIMEOUT_CYC(FAIL_TIMEOUT_CYC)
  ) u_pri_det (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .en(st_ff.ctrl.primary_fail_detect_enable),
    .osc_pin(pri_pin),
    .fail(pri_fail)
  );

  // Watchdog oscillator detector runs only while that oscillator is on
  oclf_fail_det #(
    .TIMEOUT_CYC(FAIL_TIMEOUT_CYC)
  ) u_wdt_det (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .en(st_ff.ctrl.wdt_osc_fail_detect_enable & st_ff.ctrl.wdt_osc_en),
    .osc_pin(osc_act_pin[SRC_WDT]),
    .fail(wdt_fail)
  );

  // Bus phase decode
  always_comb begin
    setup = apb_req.psel & ~apb_req.penable;
    done = apb_req.psel & apb_req.penable & st_ff.rsp.pready;
    wr = done & apb_req.pwrite;
    wbyte = apb_req.pwdata[7:0];
    clr = '0;
    if (wr && apb_req.paddr == OFF_IRQ_CLEAR) begin
      clr = apb_req.pwdata[IRQ_W-1:0];
    end
  end

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    commit = 1'b0;
    evt = '0;

    // APB answer: no wait state, pready high during the first access cycle
    nxt_st.rsp.pready = setup;
    if (setup) begin
      nxt_st.rsp.prdata = apb_req.pwrite ? 32'h0 : rd_val(apb_req.paddr, st_ff);
      nxt_st.rsp.pslverr = ~reg_hit(apb_req.paddr);
    end else if (done) begin
      nxt_st.rsp.prdata = 32'h0;
      nxt_st.rsp.pslverr = 1'b0;
    end

    // Interrupt enable register
    if (wr && apb_req.paddr == OFF_IRQ_ENABLE) begin
      nxt_st.irq_en = apb_req.pwdata[IRQ_W-1:0];
    end

    // Unlock tracker; only writes to the control register move it, so
    // accesses to other registers in between leave it where it is
    if (wr && apb_req.paddr == OFF_OSC_CTRL) begin
      case (st_ff.ul)
        UL_LOCKED: begin
          if (wbyte == UNLOCK_KEY1) begin
            nxt_st.ul = UL_HALF;
          end
        end
        UL_HALF: begin
          if (wbyte == UNLOCK_KEY2) begin
            nxt_st.ul = UL_OPEN;
          end else if (wbyte == UNLOCK_KEY1) begin
            nxt_st.ul = UL_HALF;
          end else begin
            nxt_st.ul = UL_LOCKED;
          end
        end
        UL_OPEN: begin
          // Commit the value and relock in the same edge
          nxt_st.ctrl = wbyte;
          nxt_st.ctrl.rsvd = 2'h0;
          nxt_st.ul = UL_LOCKED;
          commit = 1'b1;
        end
        default: begin
          nxt_st.ul = UL_LOCKED;
        end
      endcase
    end

    // A committed write hands the clock back to software's choice; the
    // precision oscillator keeps its own enable bit whatever is selected
    if (commit) begin
      nxt_st.fallback = 1'b0;
    end

    // Failover to the watchdog oscillator on primary failure
    if (pri_fail) begin
      evt[ST_PRI_FAIL] = 1'b1;
      if (st_ff.ctrl.wdt_osc_en && st_ff.ctrl.clock_source_select != SRC_WDT &&
          !st_ff.fallback && !commit) begin
        nxt_st.fallback = 1'b1;
        evt[ST_FALLBACK] = 1'b1;
      end
    end
    if (wdt_fail) begin
      evt[ST_WDT_FAIL] = 1'b1;
    end

    nxt_st.active_src = nxt_st.fallback ? SRC_WDT : nxt_st.ctrl.clock_source_select;

    // Sticky status: a new event wins over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~clr) | evt;
    nxt_st.irq = |(nxt_st.status & nxt_st.irq_en);

    // Non-maskable pulse, not gated by the enable register
    nxt_st.nmi = pri_fail;
  end

  // Single state register; reset restores the locked tracker and the
  // default clock set-up with the precision oscillator running
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp = st_ff.rsp;
  assign sys_clk_sel = st_ff.active_src;
  assign internal_precision_osc_en = st_ff.ctrl.internal_precision_osc;
  assign wdt_osc_en = st_ff.ctrl.wdt_osc_en;
  assign irq = st_ff.irq;
  assign clk_fail_nmi = st_ff.nmi;

endmodule

// file: oclf_pkg.sv
// Package for the oscillator control block: offsets, field layouts, reset values, timing.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.
package oclf_pkg;

  // Timing: the failure threshold is one period of a 1 kHz clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FAIL_FREQ_HZ = 1000;
  localparam int unsigned FAIL_PERIOD_NS = 1000000000 / FAIL_FREQ_HZ;
  localparam int unsigned FAIL_CYC = FAIL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned DET_CNT_W = 24;

  // Unlock key values
  localparam logic [7:0] UNLOCK_KEY1 = 8'hE7;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h18;

  // Register byte offsets
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_OSC_CTRL = 12'h000;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h008;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h00C;
  localparam logic [11:0] OFF_CLK_STATE = 12'h010;

  // Clock source codes
  localparam logic [1:0] SRC_PREC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_EXTCLK = 2'h2;
  localparam logic [1:0] SRC_WDT = 2'h3;
  localparam int unsigned NUM_SRC = 4;

  // Interrupt status bit positions
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned ST_PRI_FAIL = 0;
  localparam int unsigned ST_WDT_FAIL = 1;
  localparam int unsigned ST_FALLBACK = 2;

  // Clock state register bit positions
  localparam int unsigned CS_SRC_LSB = 0;
  localparam int unsigned CS_HALF_BIT = 2;
  localparam int unsigned CS_OPEN_BIT = 3;
  localparam int unsigned CS_FALLBACK_BIT = 4;

  // Oscillator control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic internal_precision_osc;
    logic wdt_osc_en;
    logic primary_fail_detect_enable;
    logic wdt_osc_fail_detect_enable;
    logic [1:0] rsvd;
    logic [1:0] clock_source_select;
  } oclf_ctrl_t;

  localparam oclf_ctrl_t CTRL_RST = 8'hC0;

  typedef enum logic [1:0] {UL_LOCKED, UL_HALF, UL_OPEN} oclf_unlock_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } oclf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } oclf_apb_rsp_t;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic [DET_CNT_W-1:0] cnt;
    logic fail;
  } oclf_det_t;

  typedef struct packed {
    oclf_unlock_t ul;
    oclf_ctrl_t ctrl;
    logic fallback;
    logic [1:0] active_src;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic nmi;
    oclf_apb_rsp_t rsp;
  } oclf_state_t;

  localparam oclf_state_t ST_RST = '{
    ul: UL_LOCKED,
    ctrl: CTRL_RST,
    fallback: 1'b0,
    active_src: SRC_PREC,
    status: 3'h0,
    irq_en: 3'h0,
    irq: 1'b0,
    nmi: 1'b0,
    rsp: '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0}
  };

endpackage

// file: oclf_fail_det.sv
// Oscillator activity watcher: flags a failure when its pin stops toggling.
// Assumes osc_pin is asynchronous to clk_sys; it passes three flip-flops.
`timescale 1ns/1ns
module oclf_fail_det import oclf_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = FAIL_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic en,
  input wire logic osc_pin,
  output logic fail
);

  oclf_det_t st_ff;
  oclf_det_t nxt_st;
  logic change;

  // A toggle counts once the second and third stages agree on a new level
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync = {st_ff.sync[1:0], osc_pin};
    nxt_st.fail = 1'b0;
    change = (st_ff.sync[1] == st_ff.sync[2]) && (st_ff.sync[2] != st_ff.level);
    if (change) begin
      nxt_st.level = st_ff.sync[2];
    end
    if (!en || change) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt < DET_CNT_W'(TIMEOUT_CYC - 1)) begin
      nxt_st.cnt = st_ff.cnt + DET_CNT_W'(1);
    end else if (st_ff.cnt == DET_CNT_W'(TIMEOUT_CYC - 1)) begin
      // Saturate so that a dead oscillator reports once, not every period
      nxt_st.cnt = DET_CNT_W'(TIMEOUT_CYC);
      nxt_st.fail = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fail = st_ff.fail;

endmodule

// file: oclf_osc_ctrl_props.sv
// Checker for the oscillator control block, bound to its top module.
// Assumes one clock domain, clk_sys, with synchronous active-low reset nrst.
`timescale 1ns/1ns
module oclf_osc_ctrl_props import oclf_pkg::*; #(
  parameter int unsigned FAIL_TIMEOUT_CYC = FAIL_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire oclf_apb_req_t apb_req,
  input wire oclf_apb_rsp_t apb_rsp,
  input wire logic [NUM_SRC-1:0] osc_act_pin,
  input wire logic [1:0] sys_clk_sel,
  input wire logic internal_precision_osc_en,
  input wire logic wdt_osc_en,
  input wire logic irq,
  input wire logic clk_fail_nmi
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Bus phases seen at the ports
  wire setup = apb_req.psel && !apb_req.penable;
  wire acc_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  wire ctl_wr = acc_wr && apb_req.paddr == OFF_OSC_CTRL;
  wire irq_wr = acc_wr && (apb_req.paddr == OFF_IRQ_CLEAR || apb_req.paddr == OFF_IRQ_ENABLE);

  chk_ready_next: assert property (setup |=> apb_rsp.pready) else $error("pready missing");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
  chk_err_unmapped: assert property (setup && apb_req.paddr > OFF_CLK_STATE |=> apb_rsp.pslverr
    && apb_rsp.prdata == 32'h0) else $error("unmapped access not refused");
  chk_clear_reads: assert property (setup && !apb_req.pwrite && apb_req.paddr == OFF_IRQ_CLEAR
    |=> apb_rsp.prdata == 32'h0) else $error("clear register read not zero");
  chk_reset_vals: assert property ($rose(nrst) |-> internal_precision_osc_en && wdt_osc_en
    && sys_clk_sel == SRC_PREC && !irq) else $error("outputs wrong after reset");
  // The precision oscillator enable moves only through a committed control write, never by a switch alone
  chk_osc_en_write: assert property ($changed(internal_precision_osc_en) |-> $past(ctl_wr))
    else $error("precision oscillator enable moved alone");
  chk_sel_cause: assert property ($changed(sys_clk_sel) |-> $past(ctl_wr) or ##[0:2] clk_fail_nmi)
    else $error("source changed without cause");
  chk_nmi_pulse: assert property (clk_fail_nmi |=> !clk_fail_nmi) else $error("nmi longer than a cycle");
  // A commit in the failure cycle takes priority over the fallback, so it is left out here
  chk_fallback_sel: assert property (clk_fail_nmi && wdt_osc_en && !$past(ctl_wr) |-> sys_clk_sel == SRC_WDT)
    else $error("no fallback to watchdog oscillator");
  chk_no_fallback: assert property (clk_fail_nmi && !wdt_osc_en && !$past(ctl_wr) && !$past(ctl_wr, 2)
    |-> sys_clk_sel == $past(sys_clk_sel, 2))
    else $error("fallback with watchdog oscillator off");
  chk_irq_fall: assert property ($fell(irq) |-> $past(irq_wr)) else $error("irq dropped without write");
endmodule

bind oclf_osc_ctrl oclf_osc_ctrl_props #(.FAIL_TIMEOUT_CYC(FAIL_TIMEOUT_CYC)) oclf_osc_ctrl_props_inst (
  .clk_sys(clk_sys), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp), .osc_act_pin(osc_act_pin),
  .sys_clk_sel(sys_clk_sel), .internal_precision_osc_en(internal_precision_osc_en), .wdt_osc_en(wdt_osc_en),
  .irq(irq), .clk_fail_nmi(clk_fail_nmi));

// file: tb.sv
// Testbench for the oscillator control block: unlock, commit, failover, bus errors.
// Assumes the design package and the bound checker; detector timeout shortened to TO.
`timescale 1ns/1ns
module tb import oclf_pkg::*;;
  localparam int unsigned TO = 20;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  oclf_apb_req_t rq = '0;
  oclf_apb_rsp_t rs;
  logic [3:0] pin = 4'h0;
  logic [3:0] run = 4'hF;
  logic ph = 1'b0;
  logic [1:0] sel;
  logic prec, wdt, irq, nmi, er;
  logic [31:0] rd;
  int err_total = 0;
  int n_compared = 0;
  int n;

  oclf_osc_ctrl #(.FAIL_TIMEOUT_CYC(TO)) oclf_osc_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .apb_req(rq),
    .apb_rsp(rs), .osc_act_pin(pin), .sys_clk_sel(sel), .internal_precision_osc_en(prec), .wdt_osc_en(wdt),
    .irq(irq), .clk_fail_nmi(nmi));

  // Clock and oscillator activity; a stopped pin just holds its level. Pins toggle every
  // second edge: the detector needs two equal samples in a row to count a level change.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    ph <= ~ph;
    if (ph) begin
      pin <= pin ^ run;
    end
  end

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; held until the rising edge that samples pready high, where read data
  // is taken from the values standing before that edge, then released by the same edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    rq.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (rs.pready !== 1'b1 && k < 20);
    rd = rs.prdata;
    er = rs.pslverr;
    rq <= '0;
    if (k >= 20) begin
      chk(0, 1);
      results();
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic commit(input logic [7:0] v);
    xfer(1'b1, OFF_OSC_CTRL, {24'h0, UNLOCK_KEY1});
    xfer(1'b1, OFF_OSC_CTRL, {24'h0, UNLOCK_KEY2});
    xfer(1'b1, OFF_OSC_CTRL, {24'h0, v});
  endtask

  // Stop pin 1 and count cycles up to the failure event
  task automatic wait_nmi;
    run[1] <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (nmi !== 1'b1 && n < 200);
    chk(n >= TO && n <= TO + 10, 1);
    if (n >= 200) results();
  endtask

  task automatic t_reset;
    chk({prec, wdt, sel}, 4'hC);
    rdchk(OFF_OSC_CTRL, 32'hC0);
    rdchk(OFF_CLK_STATE, 32'h0);
  endtask

  task automatic t_lock;
    xfer(1'b1, OFF_OSC_CTRL, 32'h41);
    rdchk(OFF_OSC_CTRL, 32'hC0);
    xfer(1'b1, OFF_OSC_CTRL, 32'hE7);
    xfer(1'b1, OFF_OSC_CTRL, 32'h55);
    xfer(1'b1, OFF_OSC_CTRL, 32'h18);
    rdchk(OFF_CLK_STATE, 32'h0);
    xfer(1'b1, OFF_OSC_CTRL, 32'h01);
    rdchk(OFF_OSC_CTRL, 32'hC0);
    xfer(1'b1, OFF_OSC_CTRL, 32'hE7);
    rdchk(OFF_CLK_STATE, 32'h4);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    xfer(1'b1, OFF_IRQ_ENABLE, 32'h7);
    xfer(1'b1, OFF_OSC_CTRL, 32'h18);
    rdchk(OFF_CLK_STATE, 32'h8);
    xfer(1'b1, OFF_OSC_CTRL, 32'h81);
    rdchk(OFF_OSC_CTRL, 32'h81);
    chk({prec, wdt, sel}, 4'h9);
    xfer(1'b1, OFF_OSC_CTRL, 32'h2);
    rdchk(OFF_OSC_CTRL, 32'h81);
  endtask

  task automatic t_fail;
    commit(8'hE1);
    // A running source must not trip the detector
    repeat (2 * TO) @(posedge clk_sys);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    wait_nmi();
    chk({sel, irq}, 3'h7);
    rdchk(OFF_IRQ_STATUS, 32'h5);
    rdchk(OFF_CLK_STATE, 32'h13);
    xfer(1'b1, OFF_IRQ_CLEAR, 32'h7);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    chk(irq, 0);
  endtask

  task automatic t_nofall;
    run[1] <= 1'b1;
    xfer(1'b1, OFF_IRQ_ENABLE, 32'h0);
    commit(8'hA1);
    @(posedge clk_sys);
    chk({wdt, sel}, 3'h1);
    wait_nmi();
    chk({sel, irq}, 3'h2);
    rdchk(OFF_IRQ_STATUS, 32'h1);
  endtask

  task automatic t_bus;
    xfer(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    xfer(1'b1, OFF_IRQ_STATUS, 32'h7);
    rdchk(OFF_IRQ_STATUS, 32'h1);
  endtask

  // Detection kept off for a slow external source, then a stopped watchdog oscillator
  task automatic t_slow;
    run[2] <= 1'b0;
    xfer(1'b1, OFF_IRQ_CLEAR, 32'h7);
    commit(8'h81);
    commit(8'h02);
    @(posedge clk_sys);
    chk({prec, wdt, sel}, 4'h2);
    repeat (2 * TO) @(posedge clk_sys);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    chk(nmi, 1'b0);
    run[3] <= 1'b0;
    commit(8'h52);
    repeat (2 * TO) @(posedge clk_sys);
    rdchk(OFF_IRQ_STATUS, 32'h2);
  endtask

  task automatic t_rst_mid;
    xfer(1'b1, OFF_OSC_CTRL, 32'hE7);
    xfer(1'b1, OFF_OSC_CTRL, 32'h18);
    nrst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    xfer(1'b1, OFF_OSC_CTRL, 32'h1);
    rdchk(OFF_OSC_CTRL, 32'hC0);
    chk({prec, sel}, 3'h4);
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_lock();
    t_fail();
    t_nofall();
    t_bus();
    t_slow();
    t_rst_mid();
    results();
  end
endmodule
